// *** src/wdh_control.sv ***
// Watchdog, halt entry, wake-up and reset source control over AHB-Lite
//
// The implementer's own choice: the AHB-Lite interface to the registers.
module wdh_control
  import wdh_pkg::*;
#(
  parameter int WAKE_W = 8,
  parameter int STARTUP_CYCLES = WDH_STARTUP_CYCLES
) (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core events, one-cycle pulses
  input wire logic clear_watchdog_instr,
  input wire logic clear_watchdog_first,
  input wire logic clear_watchdog_second,
  input wire logic halt_instr,
  // Interrupt view of the core
  input wire logic irq_request,
  input wire logic irq_enabled,
  input wire logic stack_full,
  // Pins from outside
  input wire logic external_clear_pin_n,
  input wire logic usb_bus_reset,
  input wire logic [WAKE_W-1:0] port_a_in,
  input wire logic watchdog_rc_oscillator,
  // Core controls
  output logic sys_clock_enable,
  output logic core_run,
  output logic chip_reset,
  output logic warm_reset,
  output logic irq_take,
  output logic halted
);
  wdh_state_e state_reg;
  logic [7:0] select_reg;
  logic [15:0] config_reg;
  logic watchdog_expired_flag, powerdown_flag;
  logic [WDH_DLY_W-1:0] delay_reg;
  logic delay_is_reset_reg, delay_irq_reg, irq_pend_reg, irq_gap_reg;
  logic [1:0] pair_reg;
  logic [1:0] div4_reg;
  logic ph_wr_reg;
  logic [7:0] ph_addr_reg;
  logic [1:0] pin_sync_reg, rc_sync_reg, usb_sync_reg;
  logic [WAKE_W-1:0] pa_s1_reg, pa_s2_reg, pa_old_reg;
  logic rc_old_reg;
  logic pin_low, rc_edge, instr_tick, tick, overflow, wd_clear, wd_on;
  logic port_wake, irq_wake, wake, usb_rst, clr_ok;
  logic [WAKE_W-1:0] wake_en;

  // Synchronise every pin before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_reg <= 2'h3;
      rc_sync_reg <= 2'h0;
      usb_sync_reg <= 2'h0;
      pa_s1_reg <= '1;
      pa_s2_reg <= '1;
      pa_old_reg <= '1;
      rc_old_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], external_clear_pin_n};
      rc_sync_reg <= {rc_sync_reg[0], watchdog_rc_oscillator};
      usb_sync_reg <= {usb_sync_reg[0], usb_bus_reset};
      pa_s1_reg <= port_a_in;
      pa_s2_reg <= pa_s1_reg;
      pa_old_reg <= pa_s2_reg;
      rc_old_reg <= rc_sync_reg[1];
    end
  end

  assign pin_low = !pin_sync_reg[1];
  assign usb_rst = usb_sync_reg[1];
  assign rc_edge = rc_sync_reg[1] && !rc_old_reg;
  assign wd_on = config_reg[WDH_CFG_ENABLE];
  assign wake_en = config_reg[WDH_CFG_WAKE_LO +: WAKE_W];

  // Instruction clock is system clock over four; stops with the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div4_reg <= 2'h0;
    end else if (state_reg != WDH_HALT) begin
      div4_reg <= div4_reg + 2'h1;
    end
  end
  assign instr_tick = (div4_reg == 2'(WDH_SYS_PER_INSTR - 1)) && (state_reg != WDH_HALT);

  // Source choice; disabled watchdog never ticks
  assign tick = wd_on && (config_reg[WDH_CFG_RC_SEL] ? rc_edge : instr_tick);

  // Paired clear needs both halves in either order
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair_reg <= 2'h0;
    end else if (clr_ok || !config_reg[WDH_CFG_TWO_CLR] || !wd_on) begin
      pair_reg <= 2'h0;
    end else begin
      pair_reg <= pair_reg | {clear_watchdog_second, clear_watchdog_first};
    end
  end
  assign clr_ok = wd_on && (config_reg[WDH_CFG_TWO_CLR]
    ? ((pair_reg | {clear_watchdog_second, clear_watchdog_first}) == 2'h3)
    : clear_watchdog_instr);

  assign wd_clear = pin_low || clr_ok || (halt_instr && wd_on) || usb_rst;

  wdh_counter u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .clear(wd_clear),
    .ratio_sel(select_reg[2:0]),
    .overflow(overflow)
  );

  // Wake sources; a request already pending at halt entry cannot wake
  assign port_wake = |(wake_en & pa_old_reg & ~pa_s2_reg);
  assign irq_wake = irq_request && !irq_pend_reg;
  assign wake = port_wake || irq_wake;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_reg <= 1'b0;
    end else if (halt_instr && state_reg == WDH_RUN) begin
      irq_pend_reg <= irq_request;
    end else if (!irq_request) begin
      irq_pend_reg <= 1'b0; // A dropped request re-arms the wake for a new one
    end
  end

  // Run, halt and start-up delay sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= WDH_DELAY;
      delay_reg <= '0;
      delay_is_reset_reg <= 1'b1;
      delay_irq_reg <= 1'b0;
    end else if (pin_low || usb_rst || (overflow && state_reg != WDH_HALT)) begin
      state_reg <= WDH_DELAY;
      delay_reg <= '0;
      delay_is_reset_reg <= 1'b1;
      delay_irq_reg <= 1'b0;
    end else begin
      case (state_reg)
        WDH_RUN: begin
          if (halt_instr) begin
            state_reg <= WDH_HALT;
          end
        end
        WDH_HALT: begin
          if (overflow || wake) begin
            state_reg <= WDH_DELAY;
            delay_reg <= '0;
            delay_is_reset_reg <= 1'b0;
            delay_irq_reg <= irq_wake && !port_wake && irq_enabled && !stack_full;
          end
        end
        WDH_DELAY: begin
          if (delay_reg == WDH_DLY_W'(STARTUP_CYCLES - 1)) begin
            state_reg <= WDH_RUN;
          end else begin
            delay_reg <= delay_reg + 1'b1;
          end
        end
        default: state_reg <= WDH_RUN;
      endcase
    end
  end

  // Interrupt entry lags the end of the dummy period by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_gap_reg <= 1'b0;
    end else begin
      irq_gap_reg <= (state_reg == WDH_DELAY) && delay_irq_reg
        && (delay_reg == WDH_DLY_W'(STARTUP_CYCLES - 1));
    end
  end
  assign irq_take = irq_gap_reg;

  // Expired flag: set by normal overflow and halted overflow, cleared by halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_expired_flag <= 1'b0;
    end else if (overflow) begin
      watchdog_expired_flag <= 1'b1;
    end else if (pin_low && state_reg == WDH_HALT) begin
      watchdog_expired_flag <= 1'b0;
    end else if (halt_instr && state_reg == WDH_RUN && wd_on) begin
      watchdog_expired_flag <= 1'b0;
    end
  end

  // Power-down flag: set by halt, cleared by power-up, clear instruction, pin wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powerdown_flag <= 1'b0;
    end else if (halt_instr && state_reg == WDH_RUN) begin
      powerdown_flag <= 1'b1;
    end else if (pin_low && state_reg == WDH_HALT) begin
      powerdown_flag <= 1'b0;
    end else if (clr_ok) begin
      powerdown_flag <= 1'b0;
    end
  end

  // Core controls; a halted overflow resets only program counter and stack
  assign halted = (state_reg == WDH_HALT);
  assign sys_clock_enable = (state_reg != WDH_HALT);
  assign core_run = (state_reg == WDH_RUN);
  assign chip_reset = (state_reg == WDH_DELAY) && delay_is_reset_reg;
  assign warm_reset = (state_reg == WDH_HALT) && overflow;

  // AHB-Lite address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready) begin
      ph_wr_reg <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      ph_addr_reg <= haddr[7:0];
    end
  end

  // Select register; chip resets restore it, halted overflow keeps it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_reg <= WDH_SELECT_RESET;
      config_reg <= WDH_CONFIG_RESET;
    end else if (pin_low || usb_rst || (overflow && state_reg != WDH_HALT)) begin
      select_reg <= WDH_SELECT_RESET;
    end else if (ph_wr_reg && ph_addr_reg == WDH_OFS_SELECT) begin
      select_reg <= hwdata[7:0] & WDH_SELECT_MASK;
    end else if (ph_wr_reg && ph_addr_reg == WDH_OFS_CONFIG) begin
      config_reg <= hwdata[15:0];
    end
  end

  // Read data; flags are read-only status
  always_comb begin
    hrdata = 32'h0000_0000;
    case (ph_addr_reg)
      WDH_OFS_SELECT: hrdata = {24'h0, select_reg};
      WDH_OFS_CONFIG: hrdata = {16'h0, config_reg};
      WDH_OFS_STATUS: hrdata = {28'h0, state_reg == WDH_DELAY, halted,
                                powerdown_flag, watchdog_expired_flag};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : wdh_control

// *** include/wdh_pkg.sv ***
// Package of constants for the watchdog, halt and reset control block
// Function
// - Select field picks prescale ratio 1:1..1:128
// - Normal overflow gives chip reset, sets expired
// - Halted overflow gives warm reset, no chip reset; sets expired
// - Pin, clear instruction, halt clear the counter
// - Single-clear option: each clear instruction clears
// - Paired option: both halves needed to clear
// - Halt stops system clock, RC keeps running
// - Halt keeps RAM, registers and ports unchanged
// - Halt sets power-down flag, clears expired
// - Halt ends on pin, interrupt, port edge, overflow
// - Power-down flag cleared by power-up or clear
// - Per-bit port wake enable; continue next instruction
// - Disabled interrupt or full stack continues next
// - Already pending interrupt cannot wake
// - Wake-up waits 1024 system clocks
// - Interrupt entry waits one more cycle
// - Four reset sources recognised
// - Flag values per reset cause
// - Start-up timer adds 1024 cycles in reset
// - Chip reset clears PC, stack, interrupts, counter
// - Clock source RC or system clock over four
// - Fixed divide by 256 before prescaler
// - Select bits sit at bits 2..0
// - Disabled watchdog makes all its operations void
package wdh_pkg;
  // Register byte offsets
  localparam logic [7:0] WDH_IDX_SELECT = 8'h09; // Register index, word sized slots
  localparam logic [7:0] WDH_OFS_SELECT = 8'(WDH_IDX_SELECT * 4);
  localparam logic [7:0] WDH_OFS_STATUS = 8'h40;
  localparam logic [7:0] WDH_OFS_CONFIG = 8'h44;
  localparam logic [7:0] WDH_SELECT_RESET = 8'h87;
  localparam logic [7:0] WDH_SELECT_MASK = 8'h87; // Bit 7 and select bits usable
  // Config field positions
  localparam int WDH_CFG_ENABLE = 0;
  localparam int WDH_CFG_RC_SEL = 1;
  localparam int WDH_CFG_TWO_CLR = 2;
  localparam int WDH_CFG_WAKE_LO = 8;
  localparam logic [15:0] WDH_CONFIG_RESET = 16'h0003;
  // Status field positions
  localparam int WDH_ST_EXPIRED = 0;
  localparam int WDH_ST_PDOWN = 1;
  localparam int WDH_ST_HALTED = 2;
  localparam int WDH_ST_DELAY = 3;
  // Timing
  localparam int WDH_FIXED_DIV = 256;
  localparam int WDH_SYS_PER_INSTR = 4;
  localparam int WDH_STARTUP_CYCLES = 1024;
  localparam int WDH_DLY_W = 11;
  localparam int WDH_CNT_W = 16; // 8 fixed stages plus up to 7 prescale plus carry
  typedef enum logic [1:0] {WDH_RUN, WDH_HALT, WDH_DELAY} wdh_state_e;
endpackage : wdh_pkg

// *** src/wdh_counter.sv ***
// Watchdog divide chain: fixed stage then programmable prescaler
module wdh_counter
  import wdh_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] ratio_sel,
  // Result
  output logic overflow
);
  logic [WDH_CNT_W-1:0] count_reg;
  logic [WDH_CNT_W-1:0] limit;

  // Period is 256 ticks times two to the select code
  assign limit = WDH_CNT_W'(WDH_FIXED_DIV) << ratio_sel;

  // Count ticks; clear wins so a cleared chain restarts from zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
    end else if (clear) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= (count_reg + 16'h0001 >= limit) ? '0 : count_reg + 16'h0001;
    end
  end

  assign overflow = tick && !clear && (count_reg + 16'h0001 >= limit);
endmodule : wdh_counter

// *** bench/wdh_core_model.sv ***
// Core model issuing clear and halt instructions
module wdh_core_model (
  // Clock and core state
  input wire logic hclk,
  input wire logic core_run,
  // Instruction pulses
  output logic clr_one,
  output logic clr_first,
  output logic clr_second,
  output logic halt_op
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {clr_one, clr_first, clr_second, halt_op} = 4'h0;
  // One-cycle pulse; a stopped core cannot execute, so wait for run
  task automatic exec(input logic [1:0] k);
    while (core_run !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    clr_one <= k == 2'd0;
    clr_first <= k == 2'd1;
    clr_second <= k == 2'd2;
    halt_op <= k == 2'd3;
    @(posedge hclk);
    {clr_one, clr_first, clr_second, halt_op} <= 4'h0;
  endtask : exec
endmodule : wdh_core_model

// *** bench/wdh_checker.sv ***
// Port assertions for the watchdog and halt control block
module wdh_checker #(
  parameter int STARTUP_CYCLES = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched outputs and events
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic halt_instr,
  input wire logic sys_clock_enable,
  input wire logic core_run,
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic halted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int low_cnt;
  // Idle core cycles, so the start-up span can be measured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= core_run ? 0 : low_cnt + 1;
    end
  end
  sequence halt_enter;
    core_run && halt_instr;
  endsequence
  sequence halt_state;
    halted && !sys_clock_enable;
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  ready_high_a: assert property (hreadyout)
    else $error("wait state seen");
  halt_entry_a: assert property (halt_enter |=> halt_state)
    else $error("halt not entered");
  halt_clock_a: assert property (halted |-> !sys_clock_enable)
    else $error("clock runs in halt");
  halt_still_a: assert property (halted |-> !core_run)
    else $error("core runs in halt");
  warm_only_a: assert property (warm_reset |-> !chip_reset)
    else $error("warm reset with chip reset");
  warm_pulse_a: assert property (warm_reset |=> !warm_reset)
    else $error("warm reset too long");
  reset_hold_a: assert property (chip_reset |-> !core_run)
    else $error("core runs in reset");
  delay_len_a: assert property ($rose(core_run) |-> low_cnt >= STARTUP_CYCLES - 1)
    else $error("start-up delay too short");
endmodule : wdh_checker

bind wdh_control wdh_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_i (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .halt_instr(halt_instr),
  .sys_clock_enable(sys_clock_enable), .core_run(core_run), .chip_reset(chip_reset),
  .warm_reset(warm_reset), .halted(halted));

// *** bench/test_watchdog_halt_reset_control.sv ***
// Testbench for the watchdog, halt and reset control block
module test_watchdog_halt_reset_control;
  import wdh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rc = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'd2;
  logic [2:0] sz = 3'h2;
  logic sel_on = 1'b1, sf = 1'b0;
  logic [7:0] pa = 8'hff;
  logic irq_req = 1'b0, irq_en = 1'b0, pin_n = 1'b1, usb = 1'b0;
  logic hreadyout, hresp, c1, cf, cs, ho, sce, core_run, chip_reset, warm_reset, irq_take;
  logic halted;
  int fail_count = 0, total_checks = 0, resets = 0, warms = 0, takes = 0, n, e, r, w, t;
  wdh_control #(.WAKE_W(8), .STARTUP_CYCLES(16)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .clear_watchdog_instr(c1), .clear_watchdog_first(cf),
    .clear_watchdog_second(cs), .halt_instr(ho), .irq_request(irq_req),
    .irq_enabled(irq_en), .stack_full(sf), .external_clear_pin_n(pin_n),
    .usb_bus_reset(usb), .port_a_in(pa), .watchdog_rc_oscillator(rc),
    .sys_clock_enable(sce), .core_run(core_run), .chip_reset(chip_reset),
    .warm_reset(warm_reset), .irq_take(irq_take), .halted(halted));
  wdh_core_model core (.hclk(hclk), .core_run(core_run), .clr_one(c1), .clr_first(cf),
    .clr_second(cs), .halt_op(ho));
  // Bus clock, and a free RC clock unrelated in phase
  always #10 hclk = ~hclk;
  always #23 rc = ~rc;
  always @(posedge chip_reset) resets++;
  always @(posedge warm_reset) warms++;
  always @(posedge irq_take) takes++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Single word transfer; read data taken at the edge closing the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= sel_on;
    hsize <= sz;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    ahb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rd_chk
  task automatic pend(input int k);
    repeat (k) @(posedge hclk);
  endtask : pend
  task automatic wait_run;
    @(posedge hclk);
    while (core_run !== 1'b1) @(posedge hclk);
  endtask : wait_run
  // Firmware keeps clearing; a differing second code sends a pair
  task automatic keep(input logic [1:0] a, input logic [1:0] b, input int k);
    repeat (k) begin
      core.exec(a);
      if (b != a) core.exec(b);
      pend(300);
    end
  endtask : keep
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the roughly 15k cycles of the tests
  initial begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run;
    rd_chk(WDH_OFS_SELECT, {24'h0, WDH_SELECT_RESET});
    rd_chk(WDH_OFS_CONFIG, {16'h0, WDH_CONFIG_RESET});
    rd_chk(8'h10, 32'h0);
    ahb(1'b1, WDH_OFS_STATUS, 32'hf);
    rd_chk(WDH_OFS_STATUS, 32'h0);
    ahb(1'b1, WDH_OFS_SELECT, 32'h7a);
    rd_chk(WDH_OFS_SELECT, 32'h2);
    // Byte sized and unselected writes must both be ignored
    sz = 3'h0;
    ahb(1'b1, WDH_OFS_SELECT, 32'h5);
    sz = 3'h2;
    rd_chk(WDH_OFS_SELECT, 32'h2);
    sel_on = 1'b0;
    ahb(1'b1, WDH_OFS_SELECT, 32'h5);
    sel_on = 1'b1;
    rd_chk(WDH_OFS_SELECT, 32'h2);
    $display("End of test 1");
    // Overflow time for the short ratios; RC period is 46 ns
    for (int s = 0; s < 4; s++) begin
      ahb(1'b1, WDH_OFS_SELECT, 32'(s));
      core.exec(2'd0);
      n = 0;
      while (chip_reset !== 1'b1) begin
        @(posedge hclk);
        n++;
      end
      e = (WDH_FIXED_DIV << s) * 46 / 20;
      chk(32'(n > e - e / 32 && n < e + e / 32), 32'h1);
      wait_run;
      rd_chk(WDH_OFS_STATUS, 32'h1);
      rd_chk(WDH_OFS_SELECT, 32'h87);
    end
    $display("End of test 2");
    r = resets;
    ahb(1'b1, WDH_OFS_SELECT, 32'h0);
    keep(2'd0, 2'd0, 4);
    chk(resets, r);
    keep(2'd1, 2'd2, 3);
    chk(resets, r + 1);
    // Restart the count before the short ratio comes back
    core.exec(2'd0);
    ahb(1'b1, WDH_OFS_CONFIG, 32'h7);
    ahb(1'b1, WDH_OFS_SELECT, 32'h0);
    keep(2'd1, 2'd2, 4);
    chk(resets, r + 1);
    keep(2'd0, 2'd0, 3);
    chk(resets, r + 2);
    $display("End of test 3");
    ahb(1'b1, WDH_OFS_CONFIG, 32'h103);
    ahb(1'b1, WDH_OFS_SELECT, 32'h7);
    r = resets;
    core.exec(2'd3);
    pend(4);
    chk(halted, 1'b1);
    chk(sce, 1'b0);
    rd_chk(WDH_OFS_STATUS, 32'h6);
    pa <= pa & 8'hfd;
    pend(40);
    chk(halted, 1'b1);
    pa <= pa & 8'hfe;
    wait_run;
    rd_chk(WDH_OFS_STATUS, 32'h2);
    rd_chk(WDH_OFS_SELECT, 32'h7);
    chk(resets, r);
    core.exec(2'd0);
    rd_chk(WDH_OFS_STATUS, 32'h0);
    pa <= pa | 8'h03;
    $display("End of test 4");
    ahb(1'b1, WDH_OFS_SELECT, 32'h0);
    w = warms;
    core.exec(2'd3);
    wait_run;
    chk(warms, w + 1);
    chk(resets, r);
    rd_chk(WDH_OFS_STATUS, 32'h3);
    rd_chk(WDH_OFS_SELECT, 32'h0);
    $display("End of test 5");
    // Watchdog off and RC source kept, so only the interrupt can wake
    ahb(1'b1, WDH_OFS_CONFIG, 32'h2);
    irq_en <= 1'b1;
    irq_req <= 1'b1;
    core.exec(2'd3);
    pend(800);
    chk(halted, 1'b1);
    irq_req <= 1'b0;
    pend(2);
    irq_req <= 1'b1;
    t = takes;
    wait_run;
    pend(2);
    chk(takes, t + 1);
    irq_req <= 1'b0;
    // Full stack: the interrupt wakes but is not taken
    sf <= 1'b1;
    core.exec(2'd3);
    pend(4);
    irq_req <= 1'b1;
    wait_run;
    pend(2);
    chk(takes, t + 1);
    irq_req <= 1'b0;
    sf <= 1'b0;
    core.exec(2'd3);
    pend(4);
    pin_n <= 1'b0;
    pend(6);
    pin_n <= 1'b1;
    wait_run;
    chk(resets, r + 1);
    rd_chk(WDH_OFS_STATUS, 32'h0);
    usb <= 1'b1;
    pend(6);
    usb <= 1'b0;
    wait_run;
    chk(resets, r + 2);
    $display("End of test 6");
    report_and_stop;
  end
endmodule : test_watchdog_halt_reset_control
